//--- hw/prm_pkg.sv
package prm_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLINK_HALF_NS = 40000000;
    localparam int BLINK_HALF_CYC = (BLINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

    // register byte addresses, low bits of haddr
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;

    // control fields
    localparam int CTRL_W = 3;
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_TX_EN = 1;
    localparam int CTRL_BLINK_EN = 2;
    localparam logic [2:0] CTRL_RESET = 3'h7;

    // latched strap vector layout
    localparam int STRAP_W = 6;
    localparam int STRAP_MODE_LSB = 0;
    localparam int STRAP_ADDR = 3;
    localparam int STRAP_PINSEL = 4;
    localparam int STRAP_CORE_REGULATOR_DISABLE_STRAP = 5;
    localparam logic [5:0] STRAP_RESET = 6'h17;

    // status fields beyond the strap copy
    localparam int STAT_LINK = 6;
    localparam int STAT_SPEED = 7;
    localparam int STAT_DUPLEX = 8;
    localparam int STAT_VALID = 9;

    // interrupt sources
    localparam int IRQ_W = 3;
    localparam int IRQ_LINK = 0;
    localparam int IRQ_RXERR = 1;
    localparam int IRQ_FRAME = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // receive dibits in wire order
    localparam logic [1:0] DIBIT_PRE = 2'h1;
    localparam logic [1:0] DIBIT_SFD = 2'h3;

    typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA} prm_rx_state_t;
endpackage

//--- hw/prm_rmii_phy_pins.sv
// Summary of operation
// - received data leaves as two separate bit outputs, bit 0 and bit 1.
// - carrier sense/data valid is high while the receive medium is not idle.
// - at 10 Mb/s data stays low until the start-of-frame delimiter arrives.
// - 10 Mb/s half duplex never echoes transmitted data onto receive outputs.
// - receive error rises when an error is seen within the current frame.
// - straps are captured after every reset and held as defaults.
// - three mode straps form the three-bit default operating mode.
// - captured address strap sets the management interface address.
// - link/activity light is on with link and blinks on traffic.
// - speed light on at 100 Mb/s with link, off at 10 Mb/s, without link or when isolated.
// - shared pin is low-active interrupt when select strap high, else clock.
// - reference clock output is a 50 MHz clock divided from the core clock when select strap low, else low.
// - reset input is active low and resets the block while low.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module prm_rmii_phy_pins #(
    parameter int BLINK_CYCLES = prm_pkg::BLINK_HALF_CYC
) (
    input wire logic sys_clk_in, // 100 MHz
    input wire logic rst_n_in, // async, active low
    input wire logic hsel_in, // slave select
    input wire logic [31:0] haddr_in, // address
    input wire logic [1:0] htrans_in, // transfer type
    input wire logic hwrite_in, // write
    input wire logic [2:0] hsize_in, // size, word only
    input wire logic [31:0] hwdata_in, // write data
    input wire logic hready_in, // bus ready
    output logic [31:0] hrdata_out, // read data
    output logic hreadyout_out, // always ready
    output logic hresp_out, // always okay
    input wire logic [1:0] txd_in, // transmit data pins
    input wire logic tx_en_in, // transmit enable pin
    output logic rxd0_out, // receive data bit 0
    output logic rxd1_out, // receive data bit 1
    output logic crs_dv_out, // carrier sense / data valid
    output logic rx_er_out, // receive error
    input wire logic [2:0] mode_strap_in, // mode straps
    input wire logic mgmt_addr_strap_in, // address strap
    input wire logic irq_or_refclk_pin_select_strap_in, // 1 irq, 0 clock
    input wire logic core_regulator_disable_strap_in, // regulator strap
    output logic [2:0] mode_out, // latched mode
    output logic mgmt_addr_out, // latched address
    output logic regulator_disable_out, // latched regulator off
    output logic straps_valid_out, // straps captured
    input wire logic med_rx_active_in, // medium not idle
    input wire logic med_rx_dibit_valid_in, // new receive dibit
    input wire logic [1:0] med_rx_dibit_in, // receive dibit
    input wire logic med_rx_err_in, // decoder error
    input wire logic link_up_in, // valid link
    input wire logic speed_100_in, // 100 Mb/s
    input wire logic full_duplex_in, // full duplex
    input wire logic isolate_in, // line isolated
    output logic [1:0] med_tx_dibit_out, // transmit dibit to medium
    output logic med_tx_en_out, // transmit active to medium
    output logic link_activity_indicator_out, // link/activity light
    output logic speed_indicator_out, // speed light
    output logic irq_out_low_out, // interrupt, active low
    output logic ref_clock_out, // 50 MHz clock if select strap low, else low
    output logic shared_pin_out, // shared pin level
    output logic shared_pin_oe_out, // shared pin drive enable
    output logic irq_out // interrupt, active high
);
    import prm_pkg::*;

    localparam int SYNC_W = 3 + STRAP_W;
    localparam int CW = $clog2(2 * BLINK_CYCLES + 1);
    localparam logic [CW-1:0] BLINK_LOAD = CW'(2 * BLINK_CYCLES);
    localparam logic [CW-1:0] BLINK_HALF = CW'(BLINK_CYCLES);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    // pin synchronisers
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [1:0] txd_s;
    logic tx_en_s;
    logic [STRAP_W-1:0] strap_s;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {core_regulator_disable_strap_in, irq_or_refclk_pin_select_strap_in,
                          mgmt_addr_strap_in, mode_strap_in, txd_in, tx_en_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign tx_en_s = sync2_reg[0];
    assign txd_s = sync2_reg[2:1];
    assign strap_s = sync2_reg[SYNC_W-1:3];

    // reference clock divider; tick marks its rising edge
    logic ref_clk_reg;
    logic tick;

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ref_clk_reg <= 1'b0;
        else
            ref_clk_reg <= ~ref_clk_reg;
    end

    assign tick = ~ref_clk_reg;

    // strap capture after the synchronisers have filled
    logic [1:0] strap_cnt_reg, strap_cnt_next;
    logic [STRAP_W-1:0] strap_reg, strap_next;
    logic strap_done_reg, strap_done_next;

    always_comb
    begin
        strap_cnt_next = strap_cnt_reg;
        strap_next = strap_reg;
        strap_done_next = strap_done_reg;
        if (!strap_done_reg)
        begin
            if (strap_cnt_reg == STRAP_SETTLE_CYC)
            begin
                strap_next = strap_s;
                strap_done_next = 1'b1;
            end
            else
                strap_cnt_next = strap_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            strap_cnt_reg <= 2'h0;
            strap_reg <= STRAP_RESET;
            strap_done_reg <= 1'b0;
        end
        else
        begin
            strap_cnt_reg <= strap_cnt_next;
            strap_reg <= strap_next;
            strap_done_reg <= strap_done_next;
        end
    end

    assign mode_out = strap_reg[STRAP_MODE_LSB +: 3];
    assign mgmt_addr_out = strap_reg[STRAP_ADDR];
    assign regulator_disable_out = strap_reg[STRAP_CORE_REGULATOR_DISABLE_STRAP];
    assign straps_valid_out = strap_done_reg;

    // register state declared early for the data paths
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;

    // receive path
    prm_rx_state_t rx_state_reg, rx_state_next;
    logic [1:0] rxd_reg, rxd_next;
    logic [1:0] prev_dibit_reg, prev_dibit_next;
    logic crs_reg, crs_next;
    logic rxer_reg, rxer_next;
    logic echo_block;
    logic frame_ev;

    assign echo_block = ~speed_100_in & ~full_duplex_in & tx_en_s;

    always_comb
    begin
        rx_state_next = rx_state_reg;
        rxd_next = rxd_reg;
        prev_dibit_next = prev_dibit_reg;
        crs_next = crs_reg;
        rxer_next = rxer_reg;
        frame_ev = 1'b0;
        if (tick)
        begin
            crs_next = med_rx_active_in & ctrl_reg[CTRL_RX_EN];
            rxer_next = med_rx_err_in & med_rx_active_in & ctrl_reg[CTRL_RX_EN];
            rxd_next = 2'h0;
            if (!crs_next)
            begin
                rx_state_next = RX_IDLE;
                prev_dibit_next = 2'h0;
            end
            else
            begin
                if (med_rx_dibit_valid_in)
                    prev_dibit_next = med_rx_dibit_in;
                case (rx_state_reg)
                    RX_IDLE:
                    begin
                        if (speed_100_in)
                        begin
                            rx_state_next = RX_DATA;
                            rxd_next = med_rx_dibit_in;
                            frame_ev = 1'b1;
                        end
                        else
                            rx_state_next = RX_PRE;
                    end
                    RX_PRE:
                    begin
                        if (med_rx_dibit_valid_in && med_rx_dibit_in == DIBIT_SFD && prev_dibit_reg == DIBIT_PRE)
                        begin
                            rx_state_next = RX_DATA;
                            rxd_next = med_rx_dibit_in;
                            frame_ev = 1'b1;
                        end
                    end
                    RX_DATA:
                    begin
                        rxd_next = med_rx_dibit_valid_in ? med_rx_dibit_in : rxd_reg;
                    end
                    default:
                        rx_state_next = RX_IDLE;
                endcase
            end
            if (echo_block)
                rxd_next = 2'h0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rx_state_reg <= RX_IDLE;
            rxd_reg <= 2'h0;
            prev_dibit_reg <= 2'h0;
            crs_reg <= 1'b0;
            rxer_reg <= 1'b0;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            rxd_reg <= rxd_next;
            prev_dibit_reg <= prev_dibit_next;
            crs_reg <= crs_next;
            rxer_reg <= rxer_next;
        end
    end

    assign rxd0_out = rxd_reg[0];
    assign rxd1_out = rxd_reg[1];
    assign crs_dv_out = crs_reg;
    assign rx_er_out = rxer_reg;

    // transmit path
    logic [1:0] tx_dibit_reg, tx_dibit_next;
    logic tx_en_reg, tx_en_next;

    always_comb
    begin
        tx_dibit_next = tx_dibit_reg;
        tx_en_next = tx_en_reg;
        if (tick)
        begin
            tx_en_next = tx_en_s & ctrl_reg[CTRL_TX_EN];
            tx_dibit_next = tx_en_next ? txd_s : 2'h0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_dibit_reg <= 2'h0;
            tx_en_reg <= 1'b0;
        end
        else
        begin
            tx_dibit_reg <= tx_dibit_next;
            tx_en_reg <= tx_en_next;
        end
    end

    assign med_tx_dibit_out = tx_dibit_reg;
    assign med_tx_en_out = tx_en_reg;

    // indicator lights; activity blinks dark for the first half period
    logic [CW-1:0] blink_cnt_reg, blink_cnt_next;
    logic led_link_reg, led_link_next;
    logic led_speed_reg, led_speed_next;

    always_comb
    begin
        blink_cnt_next = blink_cnt_reg;
        if (blink_cnt_reg != CNT_ZERO)
            blink_cnt_next = blink_cnt_reg - 1'b1;
        else if ((tx_en_s | crs_reg) & link_up_in & ctrl_reg[CTRL_BLINK_EN])
            blink_cnt_next = BLINK_LOAD;
        led_link_next = link_up_in & ~(blink_cnt_reg > BLINK_HALF);
        led_speed_next = link_up_in & speed_100_in & ~isolate_in;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            blink_cnt_reg <= CNT_ZERO;
            led_link_reg <= 1'b0;
            led_speed_reg <= 1'b0;
        end
        else
        begin
            blink_cnt_reg <= blink_cnt_next;
            led_link_reg <= led_link_next;
            led_speed_reg <= led_speed_next;
        end
    end

    assign link_activity_indicator_out = led_link_reg;
    assign speed_indicator_out = led_speed_reg;

    // bus slave and interrupt registers
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic wr_pend_reg, wr_pend_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic link_prev_reg;
    logic irq_reg, irq_next;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] w1c;
    logic addr_phase;

    assign addr_phase = hsel_in & htrans_in[1] & hready_in;

    always_comb
    begin
        events = '0;
        events[IRQ_LINK] = link_up_in ^ link_prev_reg;
        events[IRQ_RXERR] = rxer_next & ~rxer_reg;
        events[IRQ_FRAME] = frame_ev;
        w1c = '0;
        ctrl_next = ctrl_reg;
        irq_mask_next = irq_mask_reg;
        if (wr_pend_reg)
        begin
            case (addr_reg)
                ADDR_CTRL: ctrl_next = hwdata_in[CTRL_W-1:0];
                ADDR_IRQ_STAT: w1c = hwdata_in[IRQ_W-1:0];
                ADDR_IRQ_MASK: irq_mask_next = hwdata_in[IRQ_W-1:0];
                default: ;
            endcase
        end
        irq_stat_next = (irq_stat_reg & ~w1c) | events; // set wins over clear
        irq_next = |(irq_stat_next & irq_mask_next);
        addr_next = addr_phase ? haddr_in[ADDR_W-1:0] : addr_reg;
        wr_pend_next = addr_phase & hwrite_in;
        rdata_next = 32'h0000_0000;
        if (addr_phase && !hwrite_in)
        begin
            case (haddr_in[ADDR_W-1:0])
                ADDR_CTRL: rdata_next[CTRL_W-1:0] = ctrl_next;
                ADDR_STATUS:
                begin
                    rdata_next[STRAP_W-1:0] = strap_reg;
                    rdata_next[STAT_LINK] = link_up_in;
                    rdata_next[STAT_SPEED] = speed_100_in;
                    rdata_next[STAT_DUPLEX] = full_duplex_in;
                    rdata_next[STAT_VALID] = strap_done_reg;
                end
                ADDR_IRQ_STAT: rdata_next[IRQ_W-1:0] = irq_stat_next;
                ADDR_IRQ_MASK: rdata_next[IRQ_W-1:0] = irq_mask_next;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            addr_reg <= '0;
            wr_pend_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= CTRL_RESET;
            irq_stat_reg <= '0;
            irq_mask_reg <= IRQ_MASK_RESET;
            link_prev_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            addr_reg <= addr_next;
            wr_pend_reg <= wr_pend_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            link_prev_reg <= link_up_in;
            irq_reg <= irq_next;
        end
    end

    assign hrdata_out = rdata_reg;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign irq_out = irq_reg;
    assign irq_out_low_out = ~irq_reg;

    // shared pin: open-drain interrupt or driven clock
    assign shared_pin_out = strap_reg[STRAP_PINSEL] ? 1'b0 : ref_clk_reg;
    assign shared_pin_oe_out = strap_reg[STRAP_PINSEL] ? irq_reg : 1'b1;
    assign ref_clock_out = strap_reg[STRAP_PINSEL] ? 1'b0 : ref_clk_reg;
endmodule

//--- tb/prm_mac_model.sv
`timescale 1ns/1ps
module prm_mac_model (
    input wire logic clk_in, // 100 MHz
    input wire logic go_in, // send one byte
    input wire logic [7:0] byte_in, // byte, low dibit first
    output logic [1:0] txd_out, // transmit data
    output logic tx_en_out // transmit enable
);
    logic [3:0] cnt_reg = 4'h0;
    logic [7:0] sh_reg = 8'h00;
    logic [1:0] idx;
    // one dibit every two cycles
    always_ff @(posedge clk_in)
    begin
        if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
        else if (go_in)
        begin
            cnt_reg <= 4'h8;
            sh_reg <= byte_in;
        end
    end
    assign idx = 2'((4'h8 - cnt_reg) >> 1);
    assign tx_en_out = cnt_reg != 4'h0;
    // idle lines show the inverse of the last dibit
    assign txd_out = tx_en_out ? sh_reg[{idx, 1'h0} +: 2] : ~sh_reg[7:6];
endmodule

//--- tb/prm_rmii_phy_pins_props.sv
`timescale 1ns/1ps
module prm_rmii_phy_pins_props (
    input wire logic sys_clk_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic crs_dv_out, // valid
    input wire logic med_rx_active_in, // medium busy
    input wire logic rx_er_out, // rx error
    input wire logic med_rx_err_in, // decoder error
    input wire logic irq_out, // irq high
    input wire logic irq_out_low_out, // irq low
    input wire logic ref_clock_out, // ref clock
    input wire logic shared_pin_out, // pin level
    input wire logic shared_pin_oe_out, // pin enable
    input wire logic speed_indicator_out, // speed light
    input wire logic link_up_in, // link
    input wire logic speed_100_in, // speed
    input wire logic isolate_in, // isolated
    input wire logic link_activity_indicator_out, // link light
    input wire logic med_tx_en_out, // tx to medium
    input wire logic tx_en_in, // tx pin
    input wire logic straps_valid_out, // straps taken
    input wire logic [2:0] mode_out, // latched mode
    input wire logic mgmt_addr_out, // latched addr
    input wire logic [2:0] mode_strap_in, // mode straps
    input wire logic mgmt_addr_strap_in // addr strap
);
    logic speed_cond;
    assign speed_cond = link_up_in && speed_100_in && !isolate_in;
    default clocking dclk @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_crs_cause: assert property (crs_dv_out |-> $past(med_rx_active_in) || $past(med_rx_active_in, 2))
        else $error("valid without medium activity");
    a_err_cause: assert property (rx_er_out |-> $past(med_rx_err_in) || $past(med_rx_err_in, 2))
        else $error("rx error without cause");
    a_irq_polarity: assert property (irq_out_low_out == !irq_out)
        else $error("irq polarity wrong");
    a_refclk_pin: assert property (ref_clock_out |-> shared_pin_out && shared_pin_oe_out)
        else $error("shared pin not carrying clock");
    a_refclk_rate: assert property (ref_clock_out |=> !ref_clock_out ##1 ref_clock_out)
        else $error("reference clock not half rate");
    a_speed_led: assert property ($past(rst_n_in) |-> speed_indicator_out == $past(speed_cond))
        else $error("speed light wrong");
    a_link_dark: assert property ($past(rst_n_in) && !$past(link_up_in) |-> !link_activity_indicator_out)
        else $error("link light without link");
    a_tx_source: assert property (med_tx_en_out |-> $past(tx_en_in, 2) || $past(tx_en_in, 3)
        || $past(tx_en_in, 4) || $past(tx_en_in, 5))
        else $error("medium tx without enable");
    a_strap_hold: assert property (straps_valid_out && $past(straps_valid_out)
        |-> $stable(mode_out) && $stable(mgmt_addr_out))
        else $error("straps changed after capture");
    a_strap_take: assert property ($rose(straps_valid_out) |-> mode_out == $past(mode_strap_in, 2)
        && mgmt_addr_out == $past(mgmt_addr_strap_in, 2))
        else $error("straps captured wrong");
    c_frame: cover property ($rose(crs_dv_out));
    c_rx_err: cover property ($rose(rx_er_out));
    c_irq: cover property ($rose(irq_out));
    c_straps: cover property ($rose(straps_valid_out));
endmodule

//--- tb/prm_rmii_phy_pins_tb.sv
`timescale 1ns/1ps
module prm_rmii_phy_pins_tb;
    import prm_pkg::*;
    localparam int BC = 8;
    localparam logic [11:0] ADDR_IRQ_STATUS = ADDR_IRQ_STAT;
    logic sys_clk_in = 1'h0, rst_n_in = 1'h0, hsel_in = 1'h0, hwrite_in = 1'h0, go = 1'h0, b;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, q;
    logic [1:0] htrans_in = 2'h0, txd_in, med_rx_dibit_in = 2'h0, med_tx_dibit_out;
    logic [2:0] hsize_in = 3'h2, mode_strap_in = 3'h0, mode_out;
    logic [7:0] tx_byte = 8'h00;
    logic mgmt_addr_strap_in = 1'h0, irq_or_refclk_pin_select_strap_in = 1'h1;
    logic core_regulator_disable_strap_in = 1'h0, med_rx_active_in = 1'h0, med_rx_dibit_valid_in = 1'h0;
    logic med_rx_err_in = 1'h0, link_up_in = 1'h0, speed_100_in = 1'h0, full_duplex_in = 1'h0, isolate_in = 1'h0;
    logic hreadyout_out, hresp_out, tx_en_in, rxd0_out, rxd1_out, crs_dv_out, rx_er_out, mgmt_addr_out, irq_out;
    logic regulator_disable_out, straps_valid_out, med_tx_en_out, link_activity_indicator_out;
    logic speed_indicator_out, irq_out_low_out, ref_clock_out, shared_pin_out, shared_pin_oe_out;
    int n_fail = 0, checks = 0;
    prm_rmii_phy_pins #(.BLINK_CYCLES(BC)) dut_u (.sys_clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in,
        .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out,
        .txd_in, .tx_en_in, .rxd0_out, .rxd1_out, .crs_dv_out, .rx_er_out, .mode_strap_in, .mgmt_addr_strap_in,
        .irq_or_refclk_pin_select_strap_in, .core_regulator_disable_strap_in, .mode_out, .mgmt_addr_out,
        .regulator_disable_out, .straps_valid_out, .med_rx_active_in, .med_rx_dibit_valid_in, .med_rx_dibit_in,
        .med_rx_err_in, .link_up_in, .speed_100_in, .full_duplex_in, .isolate_in, .med_tx_dibit_out,
        .med_tx_en_out, .link_activity_indicator_out, .speed_indicator_out, .irq_out_low_out, .ref_clock_out,
        .shared_pin_out, .shared_pin_oe_out, .irq_out);
    prm_mac_model mac_u (.clk_in(sys_clk_in), .go_in(go), .byte_in(tx_byte), .txd_out(txd_in), .tx_en_out(tx_en_in));
    initial
    begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    task automatic end_of_test;
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkrx(input logic [3:0] e);
        chk({28'h0, crs_dv_out, rx_er_out, rxd1_out, rxd0_out}, {28'h0, e});
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel_in <= 1'h1;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        haddr_in <= {20'h0, a};
        do @(posedge sys_clk_in); while (hreadyout_out !== 1'h1);
        hsel_in <= 1'h0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge sys_clk_in); while (hreadyout_out !== 1'h1);
        q = hrdata_out;
        chk({31'h0, hresp_out}, 32'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic do_reset(input logic [2:0] m, input logic a, input logic p, input logic r);
        rst_n_in <= 1'h0;
        mode_strap_in <= m;
        mgmt_addr_strap_in <= a;
        irq_or_refclk_pin_select_strap_in <= p;
        core_regulator_disable_strap_in <= r;
        clk(12);
        rst_n_in <= 1'h1;
        clk(6);
    endtask
    task automatic rx(input logic act, input logic [1:0] d, input logic e);
        med_rx_active_in <= act;
        med_rx_dibit_valid_in <= act;
        med_rx_dibit_in <= d;
        med_rx_err_in <= e;
        clk(4);
    endtask
    task automatic send(input logic [7:0] v);
        tx_byte <= v;
        go <= 1'h1;
        clk(1);
        go <= 1'h0;
    endtask
    initial
    begin
        clk(3000);
        n_fail++;
        end_of_test();
    end
    initial
    begin
        do_reset(3'h5, 1'h1, 1'h0, 1'h1);
        rd(ADDR_STATUS, 32'h22D);
        chk({27'h0, regulator_disable_out, mgmt_addr_out, mode_out}, 32'h1D);
        b = ref_clock_out;
        clk(1);
        chk({30'h0, ref_clock_out, shared_pin_oe_out}, {30'h0, ~b, 1'h1});
        mode_strap_in <= 3'h2;
        clk(8);
        chk({29'h0, mode_out}, 32'h5);
        rd(ADDR_CTRL, 32'h7);
        rd(ADDR_IRQ_MASK, 32'h0);
        wr(12'h010, 32'hFFFF_FFFF);
        rd(12'h010, 32'h0);
        do_reset(3'h2, 1'h0, 1'h1, 1'h0);
        rd(ADDR_STATUS, 32'h212);
        chk({30'h0, ref_clock_out, shared_pin_oe_out}, 32'h0);
        link_up_in <= 1'h1;
        speed_100_in <= 1'h1;
        full_duplex_in <= 1'h1;
        rx(1'h1, 2'h2, 1'h0);
        chkrx(4'hA);
        rx(1'h1, 2'h1, 1'h0);
        chkrx(4'h9);
        rx(1'h1, 2'h3, 1'h1);
        chkrx(4'hF);
        rx(1'h0, 2'h0, 1'h0);
        chkrx(4'h0);
        rd(ADDR_IRQ_STATUS, 32'h7);
        chk({31'h0, irq_out}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h2);
        clk(1);
        chk({28'h0, irq_out, irq_out_low_out, shared_pin_oe_out, shared_pin_out}, 32'hA);
        wr(ADDR_IRQ_STATUS, 32'h2);
        clk(1);
        chk({28'h0, irq_out, irq_out_low_out, shared_pin_oe_out, shared_pin_out}, 32'h4);
        rd(ADDR_IRQ_STATUS, 32'h5);
        speed_100_in <= 1'h0;
        rx(1'h1, 2'h2, 1'h0);
        chkrx(4'h8);
        rx(1'h1, 2'h1, 1'h0);
        chkrx(4'h8);
        rx(1'h1, 2'h3, 1'h0);
        rx(1'h1, 2'h2, 1'h0);
        chkrx(4'hA);
        full_duplex_in <= 1'h0;
        send(8'hFF);
        clk(5);
        chkrx(4'h8);
        rx(1'h0, 2'h0, 1'h0);
        clk(6);
        send(8'hB4);
        do @(posedge sys_clk_in); while (med_tx_en_out !== 1'h1);
        for (int i = 0; i < 4; i++)
        begin
            chk({30'h0, med_tx_dibit_out}, {30'h0, 2'(8'hB4 >> (2 * i))});
            clk(2);
        end
        chk({31'h0, med_tx_en_out}, 32'h0);
        wr(ADDR_CTRL, 32'h5);
        send(8'hFF);
        clk(6);
        chk({31'h0, med_tx_en_out}, 32'h0);
        wr(ADDR_CTRL, 32'h7);
        for (int i = 0; i < 8; i++)
        begin
            {link_up_in, speed_100_in, isolate_in} <= 3'(i);
            clk(3);
            chk({31'h0, speed_indicator_out}, {31'h0, i == 6});
        end
        clk(3 * BC);
        chk({31'h0, link_activity_indicator_out}, 32'h1);
        rx(1'h1, 2'h2, 1'h0);
        // light goes dark up to four edges after activity, whatever the tick phase
        clk(1);
        chk({31'h0, link_activity_indicator_out}, 32'h0);
        rx(1'h0, 2'h0, 1'h0);
        clk(2 * BC + 4);
        chk({31'h0, link_activity_indicator_out}, 32'h1);
        link_up_in <= 1'h0;
        clk(2);
        chk({31'h0, link_activity_indicator_out}, 32'h0);
        end_of_test();
    end
endmodule
bind prm_rmii_phy_pins prm_rmii_phy_pins_props chk_u (.sys_clk_in, .rst_n_in, .crs_dv_out, .med_rx_active_in,
    .rx_er_out, .med_rx_err_in, .irq_out, .irq_out_low_out, .ref_clock_out, .shared_pin_out, .shared_pin_oe_out,
    .speed_indicator_out, .link_up_in, .speed_100_in, .isolate_in, .link_activity_indicator_out, .med_tx_en_out,
    .tx_en_in, .straps_valid_out, .mode_out, .mgmt_addr_out, .mode_strap_in, .mgmt_addr_strap_in);
